// >>> dcc_pkg.sv
// Constants shared by the calibration correction block.
// Assumes a 25 MHz system clock and an AXI4-Lite register bus.
package dcc_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NCH  = 8;
	localparam int GRP  = 4;
	localparam int CW   = 14;
	localparam int AW   = 9;
	localparam int FRAC = 14;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [8:0] A_CFG  = 9'h000;
	localparam logic [8:0] A_STAT = 9'h004;
	localparam logic [8:0] A_OFFA = 9'h008;
	localparam logic [8:0] A_OFFB = 9'h00c;
	localparam logic [3:0] B_IN   = 4'h8;
	localparam logic [3:0] B_GAIN = 4'h9;
	localparam logic [3:0] B_ZERO = 4'ha;
	localparam logic [3:0] B_DAC  = 4'hb;
	localparam int CF_CE   = 0;
	localparam int CF_G6   = 1;
	localparam int CF_FMT  = 2;
	localparam int CF_DUAL = 3;
	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [3:0]  CFG_RST   = 4'hb;
	localparam logic [13:0] GAIN_RST  = 14'h2000;
	localparam logic [13:0] ZERO_RST  = 14'h0000;
	localparam logic [13:0] IN_RST    = 14'h0000;
	localparam logic [13:0] DAC_RST   = 14'h0000;
	localparam logic [13:0] OFS_G6    = 14'h2666;
	localparam logic [13:0] OFS_G4    = 14'h2aab;
	localparam int          TRIM_TOL  = 3;
	localparam logic [14:0] GAIN_BIAS = 15'h2000;
	localparam logic [13:0] MSB_FLIP  = 14'h2000;
	localparam logic [13:0] CODE_MAX  = 14'h3fff;
	localparam logic [1:0]  RESP_OK   = 2'h0;
	localparam logic [1:0]  RESP_ERR  = 2'h2;
	typedef enum logic [1:0] {
		E_IDLE = 2'h1,
		E_CALC = 2'h2
	} dcc_eng_st_t;
endpackage

// >>> dcc_eng_if.sv
// Request and result path between register file and engine.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface dcc_eng_if;
	logic        start;
	logic [2:0]  ch;
	logic [13:0] code;
	logic [13:0] gain;
	logic [13:0] zero;
	logic        done;
	logic [2:0]  rch;
	logic [13:0] res;
	logic        busy;
	modport main (output start, ch, code, gain, zero,
		input done, rch, res, busy);
	modport eng (input start, ch, code, gain, zero,
		output done, rch, res, busy);
endinterface

// >>> dcc_engine.sv
// Shared gain and zero correction engine.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ps
module dcc_engine (
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	dcc_eng_if.eng    eif
);
	dcc_pkg::dcc_eng_st_t st_r, st_nxt;
	logic [2:0]         ch_r, ch_nxt;
	logic [13:0]        code_r, code_nxt;
	logic [13:0]        gain_r, gain_nxt;
	logic [13:0]        zero_r, zero_nxt;
	logic [13:0]        res_r, res_nxt;
	logic               done_r, done_nxt;
	logic [14:0]        gsum;
	logic [28:0]        prod;
	logic [14:0]        quo;
	logic signed [16:0] sum;

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	always_comb begin
		gsum = {1'b0, gain_r} + dcc_pkg::GAIN_BIAS;
		prod = {15'h0, code_r} * {14'h0, gsum};
		quo = 15'(prod >> dcc_pkg::FRAC);
		sum = $signed({2'b00, quo}) + $signed({{3{zero_r[13]}}, zero_r});
		st_nxt = st_r;
		ch_nxt = ch_r;
		code_nxt = code_r;
		gain_nxt = gain_r;
		zero_nxt = zero_r;
		res_nxt = res_r;
		done_nxt = 1'b0;
		unique case (st_r)
			dcc_pkg::E_IDLE: begin
				if (eif.start) begin
					ch_nxt = eif.ch;
					code_nxt = eif.code;
					gain_nxt = eif.gain;
					zero_nxt = eif.zero;
					st_nxt = dcc_pkg::E_CALC;
				end
			end
			dcc_pkg::E_CALC: begin
				done_nxt = 1'b1;
				st_nxt = dcc_pkg::E_IDLE;
				// Clamp so that overflow never wraps the code
				if (sum < 0)
					res_nxt = 14'h0000;
				else if (sum > $signed({3'b000, dcc_pkg::CODE_MAX}))
					res_nxt = dcc_pkg::CODE_MAX;
				else
					res_nxt = sum[13:0];
			end
			default: st_nxt = dcc_pkg::E_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r <= dcc_pkg::E_IDLE;
			ch_r <= 3'h0;
			code_r <= 14'h0000;
			gain_r <= 14'h0000;
			zero_r <= 14'h0000;
			res_r <= 14'h0000;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ch_r <= ch_nxt;
			code_r <= code_nxt;
			gain_r <= gain_nxt;
			zero_r <= zero_nxt;
			res_r <= res_nxt;
			done_r <= done_nxt;
		end
	end

	assign eif.done = done_r;
	assign eif.res = res_r;
	assign eif.rch = ch_r;
	assign eif.busy = (st_r == dcc_pkg::E_CALC);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_take;
		eif.start && st_r == dcc_pkg::E_IDLE;
	endsequence
	sequence s_finish;
		st_r == dcc_pkg::E_CALC ##1 done_r;
	endsequence
	chk_eng_turn: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_take |=> s_finish)
		else $error("engine did not finish two cycles after start");
	chk_eng_formula: assert property (@(posedge sys_clk_i)
		disable iff (rst_i)
		st_r == dcc_pkg::E_CALC && zero_r == 14'h0000 |=>
		res_r == ((((32'(code_r) * (32'(gain_r) + 32'd8192)) >> 14) >
		32'd16383) ? 14'h3fff :
		14'((32'(code_r) * (32'(gain_r) + 32'd8192)) >> 14)))
		else $error("corrected code differs from formula");
	chk_eng_clamp: assert property (@(posedge sys_clk_i)
		disable iff (rst_i)
		st_r == dcc_pkg::E_CALC && sum < 0 |=> res_r == 14'h0000)
		else $error("negative result not clamped to zero");
endmodule

// >>> dcc_regs.sv
// Register file and dispatcher of the calibration correction block.
// Assumes an AXI4-Lite master on sys_clk_i that offers address and
// data together; converter latches sit outside.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module dcc_regs #(
	parameter logic [13:0] TRIM_A_G6 = dcc_pkg::OFS_G6,
	parameter logic [13:0] TRIM_B_G6 = dcc_pkg::OFS_G6,
	parameter logic [13:0] TRIM_A_G4 = dcc_pkg::OFS_G4,
	parameter logic [13:0] TRIM_B_G4 = dcc_pkg::OFS_G4
) (
	input  wire logic          sys_clk_i,
	input  wire logic          rst_i,
	input  wire logic [8:0]    s_axi_awaddr_i,
	input  wire logic          s_axi_awvalid_i,
	output logic               s_axi_awready_o,
	input  wire logic [31:0]   s_axi_wdata_i,
	input  wire logic [3:0]    s_axi_wstrb_i,
	input  wire logic          s_axi_wvalid_i,
	output logic               s_axi_wready_o,
	output logic [1:0]         s_axi_bresp_o,
	output logic               s_axi_bvalid_o,
	input  wire logic          s_axi_bready_i,
	input  wire logic [8:0]    s_axi_araddr_i,
	input  wire logic          s_axi_arvalid_i,
	output logic               s_axi_arready_o,
	output logic [31:0]        s_axi_rdata_o,
	output logic [1:0]         s_axi_rresp_o,
	output logic               s_axi_rvalid_o,
	input  wire logic          s_axi_rready_i,
	output logic [111:0]       dac_code_o,
	output logic [27:0]        group_offset_code_o,
	output logic               offset_pd_o,
	output logic               gain_six_o
);
	localparam int N = dcc_pkg::NCH;

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	localparam int LO6 = int'(dcc_pkg::OFS_G6) - dcc_pkg::TRIM_TOL;
	localparam int HI6 = int'(dcc_pkg::OFS_G6) + dcc_pkg::TRIM_TOL;
	localparam int LO4 = int'(dcc_pkg::OFS_G4) - dcc_pkg::TRIM_TOL;
	localparam int HI4 = int'(dcc_pkg::OFS_G4) + dcc_pkg::TRIM_TOL;
	if (int'(TRIM_A_G6) < LO6 || int'(TRIM_A_G6) > HI6 ||
		int'(TRIM_B_G6) < LO6 || int'(TRIM_B_G6) > HI6 ||
		int'(TRIM_A_G4) < LO4 || int'(TRIM_A_G4) > HI4 ||
		int'(TRIM_B_G4) < LO4 || int'(TRIM_B_G4) > HI4) begin : g_bad
		$error("offset trim outside three LSB of nominal");
	end

	logic [3:0]  cfg_r, cfg_nxt;
	logic [13:0] in_r [N];
	logic [13:0] in_nxt [N];
	logic [13:0] gain_r [N];
	logic [13:0] gain_nxt [N];
	logic [13:0] zero_r [N];
	logic [13:0] zero_nxt [N];
	logic [13:0] dac_r [N];
	logic [13:0] dac_nxt [N];
	logic [13:0] off_r [2];
	logic [13:0] off_nxt [2];
	logic [7:0]  pend_r, pend_nxt;
	logic        start_r, start_nxt;
	logic [2:0]  sel_r, sel_nxt;
	logic        pd_r, pd_nxt;
	logic        aw_r, aw_nxt;
	logic        bv_r, bv_nxt;
	logic [1:0]  br_r, br_nxt;
	logic        ar_r, ar_nxt;
	logic        rv_r, rv_nxt;
	logic [1:0]  rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        wr_go, rd_go, ce, wok, rok;
	logic [8:0]  wword, rword;
	logic [3:0]  wblk, rblk;
	logic [2:0]  wch, rch;
	logic [13:0] flip;

	dcc_eng_if eif ();

	dcc_engine u_eng (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.eif       (eif)
	);

	// Byte lanes 0 and 1 carry the 14-bit field
	function automatic logic [13:0] merge(input logic [13:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [13:0] v;
		v = old;
		if (s[0])
			v[7:0] = d[7:0];
		if (s[1])
			v[13:8] = d[13:8];
		return v;
	endfunction

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign wr_go = aw_r && s_axi_awvalid_i && s_axi_wvalid_i;
	assign rd_go = ar_r && s_axi_arvalid_i;
	assign wword = {s_axi_awaddr_i[8:2], 2'b00};
	assign rword = {s_axi_araddr_i[8:2], 2'b00};
	assign wblk = s_axi_awaddr_i[8:5];
	assign rblk = s_axi_araddr_i[8:5];
	assign wch = s_axi_awaddr_i[4:2];
	assign rch = s_axi_araddr_i[4:2];
	assign ce = cfg_r[dcc_pkg::CF_CE];
	// Twos complement DAC and offset codes are held as straight binary; input codes are held as written
	assign flip = cfg_r[dcc_pkg::CF_FMT] ? dcc_pkg::MSB_FLIP : 14'h0000;

	assign eif.start = start_r;
	assign eif.ch = sel_r;
	assign eif.code = in_r[sel_r] ^ flip;
	assign eif.gain = gain_r[sel_r];
	assign eif.zero = zero_r[sel_r];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		cfg_nxt = cfg_r;
		in_nxt = in_r;
		gain_nxt = gain_r;
		zero_nxt = zero_r;
		dac_nxt = dac_r;
		off_nxt = off_r;
		pend_nxt = pend_r;
		start_nxt = 1'b0;
		sel_nxt = sel_r;
		aw_nxt = s_axi_awvalid_i && s_axi_wvalid_i && !aw_r && !bv_r;
		bv_nxt = bv_r && !s_axi_bready_i;
		br_nxt = br_r;
		ar_nxt = s_axi_arvalid_i && !ar_r && !rv_r;
		rv_nxt = rv_r && !s_axi_rready_i;
		rr_nxt = rr_r;
		rd_nxt = rd_r;
		wok = 1'b1;
		rok = 1'b1;
		// Lowest pending channel goes first; engine takes one at a time
		if (!start_r && !eif.busy && |pend_r) begin
			start_nxt = 1'b1;
			for (int i = N - 1; i >= 0; i--)
				if (pend_r[i])
					sel_nxt = 3'(i);
			pend_nxt[sel_nxt] = 1'b0;
		end
		if (eif.done)
			dac_nxt[eif.rch] = eif.res;
		// A host write after this point wins over a finishing result
		if (wr_go) begin
			bv_nxt = 1'b1;
			if (wword == dcc_pkg::A_CFG) begin
				if (s_axi_wstrb_i[0])
					cfg_nxt = s_axi_wdata_i[3:0];
				if (cfg_nxt[dcc_pkg::CF_G6] != cfg_r[dcc_pkg::CF_G6]) begin
					off_nxt[0] = cfg_nxt[dcc_pkg::CF_G6] ?
						TRIM_A_G6 : TRIM_A_G4;
					off_nxt[1] = cfg_nxt[dcc_pkg::CF_G6] ?
						TRIM_B_G6 : TRIM_B_G4;
				end
			end else if (wword == dcc_pkg::A_OFFA)
				off_nxt[0] = merge(off_r[0] ^ flip, s_axi_wdata_i,
					s_axi_wstrb_i) ^ flip;
			else if (wword == dcc_pkg::A_OFFB)
				off_nxt[1] = merge(off_r[1] ^ flip, s_axi_wdata_i,
					s_axi_wstrb_i) ^ flip;
			else if (wblk == dcc_pkg::B_IN) begin
				in_nxt[wch] = merge(in_r[wch], s_axi_wdata_i, s_axi_wstrb_i);
				if (ce)
					pend_nxt[wch] = 1'b1;
				else
					dac_nxt[wch] = in_nxt[wch] ^ flip;
			end else if (wblk == dcc_pkg::B_GAIN) begin
				gain_nxt[wch] = merge(gain_r[wch], s_axi_wdata_i,
					s_axi_wstrb_i);
				if (ce)
					pend_nxt[wch] = 1'b1;
			end else if (wblk == dcc_pkg::B_ZERO) begin
				zero_nxt[wch] = merge(zero_r[wch], s_axi_wdata_i,
					s_axi_wstrb_i);
				if (ce)
					pend_nxt[wch] = 1'b1;
			end else if (wblk == dcc_pkg::B_DAC)
				dac_nxt[wch] = merge(dac_r[wch] ^ flip, s_axi_wdata_i,
					s_axi_wstrb_i) ^ flip;
			else if (wword != dcc_pkg::A_STAT)
				wok = 1'b0;
			br_nxt = wok ? dcc_pkg::RESP_OK : dcc_pkg::RESP_ERR;
		end
		pd_nxt = !cfg_nxt[dcc_pkg::CF_DUAL];
		if (rd_go) begin
			rv_nxt = 1'b1;
			rd_nxt = 32'h0;
			if (rword == dcc_pkg::A_CFG)
				rd_nxt = {28'h0, cfg_r};
			else if (rword == dcc_pkg::A_STAT)
				rd_nxt = {23'h0, eif.busy | start_r, pend_r};
			else if (rword == dcc_pkg::A_OFFA)
				rd_nxt = {18'h0, off_r[0] ^ flip};
			else if (rword == dcc_pkg::A_OFFB)
				rd_nxt = {18'h0, off_r[1] ^ flip};
			else if (rblk == dcc_pkg::B_IN)
				rd_nxt = {18'h0, in_r[rch]};
			else if (rblk == dcc_pkg::B_GAIN)
				rd_nxt = {18'h0, gain_r[rch]};
			else if (rblk == dcc_pkg::B_ZERO)
				rd_nxt = {18'h0, zero_r[rch]};
			else if (rblk == dcc_pkg::B_DAC)
				rd_nxt = {18'h0, dac_r[rch] ^ flip};
			else
				rok = 1'b0;
			rr_nxt = rok ? dcc_pkg::RESP_OK : dcc_pkg::RESP_ERR;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_r <= dcc_pkg::CFG_RST;
			for (int i = 0; i < N; i++) begin
				in_r[i] <= dcc_pkg::IN_RST;
				gain_r[i] <= dcc_pkg::GAIN_RST;
				zero_r[i] <= dcc_pkg::ZERO_RST;
				dac_r[i] <= dcc_pkg::DAC_RST;
			end
			off_r[0] <= TRIM_A_G6;
			off_r[1] <= TRIM_B_G6;
			pend_r <= 8'h00;
			start_r <= 1'b0;
			sel_r <= 3'h0;
			pd_r <= 1'b0;
			aw_r <= 1'b0;
			bv_r <= 1'b0;
			br_r <= dcc_pkg::RESP_OK;
			ar_r <= 1'b0;
			rv_r <= 1'b0;
			rr_r <= dcc_pkg::RESP_OK;
			rd_r <= 32'h0;
		end else begin
			cfg_r <= cfg_nxt;
			in_r <= in_nxt;
			gain_r <= gain_nxt;
			zero_r <= zero_nxt;
			dac_r <= dac_nxt;
			off_r <= off_nxt;
			pend_r <= pend_nxt;
			start_r <= start_nxt;
			sel_r <= sel_nxt;
			pd_r <= pd_nxt;
			aw_r <= aw_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			ar_r <= ar_nxt;
			rv_r <= rv_nxt;
			rr_r <= rr_nxt;
			rd_r <= rd_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	for (genvar g = 0; g < N; g++) begin : g_dac
		assign dac_code_o[g*dcc_pkg::CW +: dcc_pkg::CW] = dac_r[g];
	end
	for (genvar g = 0; g < N / dcc_pkg::GRP; g++) begin : g_grp
		assign group_offset_code_o[g*dcc_pkg::CW +: dcc_pkg::CW] =
			off_r[g];
	end
	assign offset_pd_o = pd_r;
	assign gain_six_o = cfg_r[dcc_pkg::CF_G6];
	assign s_axi_awready_o = aw_r;
	assign s_axi_wready_o = aw_r;
	assign s_axi_bvalid_o = bv_r;
	assign s_axi_bresp_o = br_r;
	assign s_axi_arready_o = ar_r;
	assign s_axi_rvalid_o = rv_r;
	assign s_axi_rresp_o = rr_r;
	assign s_axi_rdata_o = rd_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	chk_queue_set: assert property (
		wr_go && ce && (wblk == dcc_pkg::B_IN || wblk == dcc_pkg::B_GAIN ||
		wblk == dcc_pkg::B_ZERO) |=> pend_r[$past(wch)])
		else $error("correction request lost");
	chk_direct_load: assert property (
		wr_go && !ce && wblk == dcc_pkg::B_IN && s_axi_wstrb_i[1:0] == 2'h3
		|=> dac_r[$past(wch)] == ($past(s_axi_wdata_i[13:0]) ^ flip))
		else $error("uncorrected input not loaded");
	chk_no_calc: assert property (
		wr_go && !ce && !pend_r[wch] &&
		(wblk == dcc_pkg::B_GAIN || wblk == dcc_pkg::B_ZERO)
		|=> !pend_r[$past(wch)])
		else $error("calculation queued while correction off");
	chk_result_load: assert property (
		eif.done && !(wr_go && (wblk == dcc_pkg::B_DAC ||
		(wblk == dcc_pkg::B_IN && !ce)))
		|=> dac_r[$past(eif.rch)] == $past(eif.res))
		else $error("engine result not loaded");
	chk_drain_start: assert property (
		|pend_r && !eif.busy && !start_r |=> start_r ##1 eif.busy)
		else $error("pending request not dispatched");
	chk_gain_reload: assert property (
		$changed(cfg_r[dcc_pkg::CF_G6]) |->
		off_r[0] == (cfg_r[dcc_pkg::CF_G6] ? TRIM_A_G6 : TRIM_A_G4) &&
		off_r[1] == (cfg_r[dcc_pkg::CF_G6] ? TRIM_B_G6 : TRIM_B_G4))
		else $error("offset code not reloaded on gain change");
	chk_offset_pd: assert property (
		!cfg_r[dcc_pkg::CF_DUAL] |-> offset_pd_o)
		else $error("offset converters not powered down");
	chk_wr_resp: assert property (
		wr_go |=> s_axi_bvalid_o [*1] ##0 !s_axi_awready_o)
		else $error("write response missing");
	chk_rd_resp: assert property (
		rd_go |=> s_axi_rvalid_o && !s_axi_arready_o)
		else $error("read response missing");
endmodule

// >>> dcc_host_model.sv
// Host model: an AXI4-Lite master that writes and reads the block.
// Assumes slave registers change on the rising edge of sys_clk_i.
`timescale 1ns/1ps
module dcc_host_model (
	input  wire logic        sys_clk_i,
	output logic [8:0]       awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic [1:0]  bresp_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	output logic [8:0]       araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	// ----------------------------------------
	// Idle values
	// ----------------------------------------
	initial begin
		awaddr_o  = 9'h000;
		awvalid_o = 1'b0;
		wdata_o   = 32'h00000000;
		wstrb_o   = 4'h0;
		wvalid_o  = 1'b0;
		bready_o  = 1'b0;
		araddr_o  = 9'h000;
		arvalid_o = 1'b0;
		rready_o  = 1'b0;
	end
	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// Gain words go out straight binary, zero words twos complement
	task automatic wr(input logic [8:0] a, input logic [31:0] d,
		output logic [1:0] resp);
		logic aw_left;
		logic w_left;
		aw_left = 1'b1;
		w_left  = 1'b1;
		@(posedge sys_clk_i);
		awaddr_o  <= a;
		wdata_o   <= d;
		wstrb_o   <= 4'hf;
		awvalid_o <= 1'b1;
		wvalid_o  <= 1'b1;
		bready_o  <= 1'b1;
		forever begin
			@(posedge sys_clk_i);
			// Released payload is scrambled so a stale value cannot pass
			if (aw_left && awready_i) begin
				awvalid_o <= 1'b0;
				awaddr_o  <= ~a;
				aw_left = 1'b0;
			end
			if (w_left && wready_i) begin
				wvalid_o <= 1'b0;
				wdata_o  <= ~d;
				w_left = 1'b0;
			end
			if (bvalid_i) begin
				resp = bresp_i;
				bready_o <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [8:0] a, output logic [31:0] d,
		output logic [1:0] resp);
		@(posedge sys_clk_i);
		araddr_o  <= a;
		arvalid_o <= 1'b1;
		rready_o  <= 1'b1;
		forever begin
			@(posedge sys_clk_i);
			if (arvalid_o && arready_i) begin
				arvalid_o <= 1'b0;
				araddr_o  <= ~a;
			end
			if (rvalid_i) begin
				d = rdata_i;
				resp = rresp_i;
				rready_o <= 1'b0;
				break;
			end
		end
	endtask
endmodule

// >>> dac_calibration_correction_engine_tb_top.sv
// Self-checking bench of the calibration correction block.
// Assumes the host model as bus master and default trim parameters.
`timescale 1ns/1ps
module dac_calibration_correction_engine_tb_top;
	logic         sys_clk_i;
	logic         rst_i;
	logic [8:0]   awaddr;
	logic         awvalid;
	logic         awready;
	logic [31:0]  wdata;
	logic [3:0]   wstrb;
	logic         wvalid;
	logic         wready;
	logic [1:0]   bresp;
	logic         bvalid;
	logic         bready;
	logic [8:0]   araddr;
	logic         arvalid;
	logic         arready;
	logic [31:0]  rdata;
	logic [1:0]   rresp;
	logic         rvalid;
	logic         rready;
	logic [111:0] dac_code;
	logic [27:0]  ofs_code;
	logic         ofs_pd;
	logic         gain_six;
	int           errors;
	int           compares;
	int           gset [8];
	int           zset [8];
	logic [31:0]  rv;
	logic [1:0]   rs;

	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	dcc_regs dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .dac_code_o(dac_code),
		.group_offset_code_o(ofs_code), .offset_pd_o(ofs_pd),
		.gain_six_o(gain_six));

	dcc_host_model host_u (.sys_clk_i(sys_clk_i), .awaddr_o(awaddr),
		.awvalid_o(awvalid), .awready_i(awready), .wdata_o(wdata),
		.wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
		.bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
		.araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready),
		.rdata_i(rdata), .rresp_i(rresp), .rvalid_i(rvalid),
		.rready_o(rready));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] expc(input int code, input int n);
		int r;
		r = (code * (gset[n] + 8192)) / 16384;
		r = r + ((zset[n] >= 8192) ? zset[n] - 16384 : zset[n]);
		if (r < 0) r = 0;
		if (r > 16383) r = 16383;
		return r;
	endfunction

	function automatic logic [31:0] dac(input int n);
		return {18'h0, dac_code[14*n +: 14]};
	endfunction

	task automatic wreg(input logic [8:0] a, input logic [31:0] d);
		host_u.wr(a, d, rs);
		chk({30'h0, rs}, {30'h0, dcc_pkg::RESP_OK});
	endtask

	task automatic rchk(input logic [8:0] a, input logic [31:0] e);
		host_u.rd(a, rv, rs);
		chk(rv, e);
	endtask

	task automatic close_out;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		errors++;
		close_out();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		errors = 0;
		compares = 0;
		rst_i = 1'b1;
		for (int n = 0; n < 8; n++) begin
			gset[n] = 8192;
			zset[n] = 0;
		end
		repeat (6) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		// Power-on values
		rchk(dcc_pkg::A_CFG, 32'h0000000b);
		for (int n = 0; n < 8; n++) begin
			rchk(9'h120 + 9'(4 * n), 32'h00002000);
			rchk(9'h140 + 9'(4 * n), 32'h00000000);
			rchk(9'h100 + 9'(4 * n), 32'h00000000);
		end
		chk({4'h0, ofs_code}, {4'h0, 14'h2666, 14'h2666});
		chk({31'h0, gain_six}, 32'h1);
		chk({31'h0, ofs_pd}, 32'h0);
		// Group offset codes are independent
		wreg(dcc_pkg::A_OFFA, 32'h00001234);
		rchk(dcc_pkg::A_OFFB, 32'h00002666);
		chk({18'h0, ofs_code[13:0]}, 32'h00001234);
		// Corrected path on channel 3, edges of gain and zero
		wreg(9'h10c, 32'h00003000);
		repeat (10) @(posedge sys_clk_i);
		chk(dac(3), expc(12288, 3));
		gset[3] = 16383;
		wreg(9'h12c, 32'h00003fff);
		repeat (10) @(posedge sys_clk_i);
		chk(dac(3), 32'h00003fff);
		gset[3] = 0;
		wreg(9'h12c, 32'h00000000);
		repeat (10) @(posedge sys_clk_i);
		chk(dac(3), 32'h00001800);
		for (int k = 0; k < 3; k++) begin
			zset[3] = (k == 0) ? 12288 : (k == 1) ? 8191 : 8192;
			wreg(9'h14c, 32'(zset[3]));
			repeat (10) @(posedge sys_clk_i);
			chk(dac(3), expc(12288, 3));
		end
		// Back-to-back input writes share one engine
		for (int n = 0; n < 8; n++) begin
			wreg(9'h100 + 9'(4 * n), 32'((n + 1) * 1024));
		end
		repeat (40) @(posedge sys_clk_i);
		for (int n = 0; n < 8; n++) begin
			chk(dac(n), expc((n + 1) * 1024, n));
		end
		rchk(dcc_pkg::A_STAT, 32'h00000000);
		// Correction off
		wreg(dcc_pkg::A_CFG, 32'h0000000a);
		wreg(9'h114, 32'h00000123);
		@(posedge sys_clk_i);
		chk(dac(5), 32'h00000123);
		wreg(9'h134, 32'h00000001);
		wreg(9'h154, 32'h00003ffe);
		repeat (10) @(posedge sys_clk_i);
		chk(dac(5), 32'h00000123);
		rchk(9'h134, 32'h00000001);
		rchk(9'h154, 32'h00003ffe);
		wreg(9'h178, 32'h00002222);
		@(posedge sys_clk_i);
		chk(dac(6), 32'h00002222);
		// Gain select and supply mode
		wreg(dcc_pkg::A_CFG, 32'h00000008);
		@(posedge sys_clk_i);
		chk({4'h0, ofs_code}, {4'h0, 14'h2aab, 14'h2aab});
		chk({31'h0, gain_six}, 32'h0);
		wreg(dcc_pkg::A_CFG, 32'h00000000);
		@(posedge sys_clk_i);
		chk({31'h0, ofs_pd}, 32'h1);
		// Unmapped place
		host_u.wr(9'h010, 32'h0000abcd, rs);
		chk({30'h0, rs}, {30'h0, dcc_pkg::RESP_ERR});
		host_u.rd(9'h010, rv, rs);
		chk({30'h0, rs}, {30'h0, dcc_pkg::RESP_ERR});
		chk(rv, 32'h00000000);
		wreg(dcc_pkg::A_STAT, 32'h000001ff);
		rchk(dcc_pkg::A_STAT, 32'h00000000);
		// Twos complement format with correction on
		wreg(dcc_pkg::A_CFG, 32'h0000000f);
		@(posedge sys_clk_i);
		chk({4'h0, ofs_code}, {4'h0, 14'h2666, 14'h2666});
		wreg(9'h11c, 32'h00000000);
		repeat (10) @(posedge sys_clk_i);
		chk(dac(7), 32'h00002000);
		rchk(9'h11c, 32'h00000000);
		rchk(9'h17c, 32'h00000000);
		wreg(dcc_pkg::A_OFFB, 32'h00000000);
		chk({18'h0, ofs_code[27:14]}, 32'h00002000);
		rchk(dcc_pkg::A_OFFB, 32'h00000000);
		close_out();
	end
endmodule
